/* File: shared/pgwr_params.svh */
// constants of the page-write register interface
`ifndef PGWR_PARAMS_SVH
`define PGWR_PARAMS_SVH

// serial slave address: six fixed bits, the lowest taken from the address-select pin
`define PGWR_SLAVE_BASE 6'h14

// page geometry
`define PGWR_PAGE_BITS 2
`define PGWR_NV_PAGES 32

// configuration space and its user area
`define PGWR_CFG_LAST 8'h4B
`define PGWR_HOLE_FIRST 8'h4C
`define PGWR_USER_FIRST 8'h50
`define PGWR_RSVD_FIRST 8'h58

// operations space
`define PGWR_OPS_FIRST 8'h80
`define PGWR_STATUS_LAST 8'h83
`define PGWR_BALANCE 8'h84
`define PGWR_ANALOG_OUT 8'h85
`define PGWR_SWITCH_CTRL 8'h86
`define PGWR_OVERRIDE 8'h87
`define PGWR_FORCE_OPS 8'h88
`define PGWR_NV_WR_EN 8'h89
`define PGWR_MEAS_FIRST 8'h8A
`define PGWR_OPS_LAST 8'hAB

// reset values
`define PGWR_BYTE_RST 8'h00
`define PGWR_PTR_RST 8'h00

// buffer shape
`define PGWR_FIFO_WIDTH 16
`define PGWR_FIFO_DEPTH 8

// internal write cycle after a stop
`define PGWR_WCYC_MS 30
`define PGWR_CLK_KHZ 125000
`define PGWR_WCYC_CYCLES (`PGWR_WCYC_MS * `PGWR_CLK_KHZ)

`endif

/* File: shared/pgwr_pkg.sv */
// types of the page-write register interface
package pgwr_pkg;

    // serial receive state
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_DEV = 3'b001,
        ST_REG = 3'b010,
        ST_DATA = 3'b011,
        ST_ACK = 3'b100,
        ST_SKIP = 3'b101
    } pgwr_state_t;

endpackage

/* File: core/pgwr_top.sv */
// serial slave write path with page wrap, write buffer and register map
`timescale 1ns/1ps
`include "pgwr_params.svh"

// ************************************************************
// write buffer
// ************************************************************

module pgwr_fifo #(
    parameter int WIDTH = `PGWR_FIFO_WIDTH,
    parameter int DEPTH = `PGWR_FIFO_DEPTH
) (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] store [0:DEPTH-1];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
    logic push;
    logic pop;

    // full and empty come straight from the fill count
    assign in_ready = (count != (AW+1)'(DEPTH));
    assign out_valid = (count != '0);
    assign out_data = store[rd_ptr];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    // storage has no reset; only words behind the count are ever read
    always_ff @(posedge mclk) begin
        if (push) begin
            store[wr_ptr] <= in_data;
        end
    end

    // pointers wrap at the depth, which need not be a power of two
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else begin
            if (push) begin
                wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + AW'(1);
            end
            if (pop) begin
                rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + AW'(1);
            end
            if (push && !pop) begin
                count <= count + (AW+1)'(1);
            end else if (pop && !push) begin
                count <= count - (AW+1)'(1);
            end
        end
    end
endmodule // pgwr_fifo

// ************************************************************
// serial front end and register map
// ************************************************************

module pgwr_top #(
    parameter int WCYC_CYCLES = `PGWR_WCYC_CYCLES
) (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic scl,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    output logic scl_out,
    output logic scl_oe,
    input wire logic addr_sel,
    input wire logic shadow_hold,
    input wire logic [7:0] cfg_rd_addr,
    output logic [15:0] cfg_rd_word,
    output logic [7:0] addr_counter,
    output logic write_busy,
    output logic [7:0] balance_control,
    output logic [7:0] analog_output_select,
    output logic [7:0] switch_control_override,
    output logic [7:0] override_control,
    output logic [7:0] forced_operation,
    output logic nonvolatile_write_enable
);
    localparam int CW = $clog2(WCYC_CYCLES + 1);

    pgwr_pkg::pgwr_state_t state;
    pgwr_pkg::pgwr_state_t after_ack;
    logic scl_q;
    logic sda_q;
    logic rise;
    logic fall;
    logic start_seen;
    logic stop_seen;
    logic [7:0] shreg;
    logic [3:0] bitcnt;
    logic [7:0] ptr;
    logic [7:0] next_ptr;
    logic stretch;
    logic wrote;
    logic [CW-1:0] busy_cnt;
    logic push_valid;
    logic [15:0] push_data;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic [15:0] fifo_out_data;
    logic drain_ready;
    logic drain;
    logic [7:0] drain_addr;
    logic [7:0] drain_byte;
    logic [6:0] own_addr;
    logic protect;
    logic [7:0] regs [0:255];

    // line edges; inputs are already synchronous to mclk
    assign rise = scl && !scl_q;
    assign fall = !scl && scl_q;
    assign start_seen = scl && scl_q && sda_q && !sda_in;
    assign stop_seen = scl && scl_q && !sda_q && sda_in;
    assign own_addr = {`PGWR_SLAVE_BASE, addr_sel};

    // stay inside the page: the two low bits count modulo four
    assign next_ptr = {ptr[7:`PGWR_PAGE_BITS], ptr[`PGWR_PAGE_BITS-1:0] + 2'h1};

    // holes, reserved space, status and measurements refuse writes
    always_comb begin
        protect = 1'b0;
        if (ptr >= `PGWR_HOLE_FIRST && ptr < `PGWR_USER_FIRST) begin
            protect = 1'b1;
        end
        if (ptr >= `PGWR_RSVD_FIRST && ptr < `PGWR_OPS_FIRST) begin
            protect = 1'b1;
        end
        if (ptr >= `PGWR_OPS_FIRST && ptr <= `PGWR_STATUS_LAST) begin
            protect = 1'b1;
        end
        if (ptr >= `PGWR_MEAS_FIRST) begin
            protect = 1'b1;
        end
    end

    // previous line levels for edge and condition detection
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else begin
            scl_q <= scl;
            sda_q <= sda_in;
        end
    end

    // byte framing, acknowledge and the address counter
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            state <= pgwr_pkg::ST_IDLE;
            after_ack <= pgwr_pkg::ST_IDLE;
            shreg <= `PGWR_BYTE_RST;
            bitcnt <= 4'h0;
            ptr <= `PGWR_PTR_RST;
            stretch <= 1'b0;
            sda_oe <= 1'b0;
            push_valid <= 1'b0;
            push_data <= 16'h0000;
        end else begin
            push_valid <= 1'b0;
            if (write_busy) begin
                // inputs dead during the write cycle, output released
                state <= pgwr_pkg::ST_IDLE;
                sda_oe <= 1'b0;
                stretch <= 1'b0;
            end else if (start_seen) begin
                state <= pgwr_pkg::ST_DEV;
                bitcnt <= 4'h0;
                sda_oe <= 1'b0;
                stretch <= 1'b0;
            end else if (stop_seen) begin
                state <= pgwr_pkg::ST_IDLE;
                sda_oe <= 1'b0;
                stretch <= 1'b0;
            end else if (stretch) begin
                // clock held low until the buffer has room
                if (fifo_in_ready) begin
                    stretch <= 1'b0;
                    push_valid <= 1'b1;
                    push_data <= {ptr, shreg};
                    ptr <= next_ptr;
                    sda_oe <= 1'b1;
                    after_ack <= pgwr_pkg::ST_DATA;
                    state <= pgwr_pkg::ST_ACK;
                    bitcnt <= 4'h0;
                end
            end else begin
                unique case (state)
                    pgwr_pkg::ST_IDLE,
                    pgwr_pkg::ST_SKIP: begin
                        sda_oe <= 1'b0;
                    end
                    pgwr_pkg::ST_ACK: begin
                        // release the line after the ninth clock
                        if (fall) begin
                            sda_oe <= 1'b0;
                            state <= after_ack;
                        end
                    end
                    pgwr_pkg::ST_DEV,
                    pgwr_pkg::ST_REG,
                    pgwr_pkg::ST_DATA: begin
                        if (rise && bitcnt != 4'h8) begin
                            shreg <= {shreg[6:0], sda_in};
                            bitcnt <= bitcnt + 4'h1;
                        end else if (fall && bitcnt == 4'h8) begin
                            bitcnt <= 4'h0;
                            if (state == pgwr_pkg::ST_DEV) begin
                                // reads are served elsewhere; only writes answered
                                if (shreg[7:1] == own_addr && !shreg[0]) begin
                                    sda_oe <= 1'b1;
                                    after_ack <= pgwr_pkg::ST_REG;
                                    state <= pgwr_pkg::ST_ACK;
                                end else begin
                                    state <= pgwr_pkg::ST_SKIP;
                                end
                            end else if (state == pgwr_pkg::ST_REG) begin
                                ptr <= shreg;
                                sda_oe <= 1'b1;
                                after_ack <= pgwr_pkg::ST_DATA;
                                state <= pgwr_pkg::ST_ACK;
                            end else if (protect) begin
                                state <= pgwr_pkg::ST_SKIP;
                            end else if (fifo_in_ready) begin
                                push_valid <= 1'b1;
                                push_data <= {ptr, shreg};
                                ptr <= next_ptr;
                                sda_oe <= 1'b1;
                                after_ack <= pgwr_pkg::ST_DATA;
                                state <= pgwr_pkg::ST_ACK;
                            end else begin
                                stretch <= 1'b1;
                            end
                        end
                    end
                    default: begin
                        state <= pgwr_pkg::ST_IDLE;
                    end
                endcase
            end
        end
    end

    // clock stretch drive, held one cycle past release so the ack settles before the clock rises
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            scl_oe <= 1'b0;
            scl_out <= 1'b0;
            sda_out <= 1'b0;
        end else begin
            scl_oe <= stretch && !write_busy;
            scl_out <= 1'b0;
            sda_out <= 1'b0;
        end
    end

    // remember that this transaction stored data, then run the write cycle
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            wrote <= 1'b0;
            write_busy <= 1'b0;
            busy_cnt <= '0;
        end else begin
            if (write_busy) begin
                wrote <= 1'b0;
                if (busy_cnt == CW'(1)) begin
                    write_busy <= 1'b0;
                end
                busy_cnt <= busy_cnt - CW'(1);
            end else if (stop_seen && wrote) begin
                write_busy <= 1'b1;
                busy_cnt <= CW'(WCYC_CYCLES);
                wrote <= 1'b0;
            end else if (start_seen) begin
                wrote <= 1'b0;
            end else if (push_valid) begin
                wrote <= 1'b1;
            end
        end
    end

    // the buffer decouples the serial side from the register array
    pgwr_fifo #(
        .WIDTH(`PGWR_FIFO_WIDTH),
        .DEPTH(`PGWR_FIFO_DEPTH)
    ) u_fifo (
        .mclk(mclk),
        .nrst(nrst),
        .in_valid(push_valid),
        .in_ready(fifo_in_ready),
        .in_data(push_data),
        .out_valid(fifo_out_valid),
        .out_ready(drain_ready),
        .out_data(fifo_out_data)
    );

    // the monitor core may freeze the shadow while it scans
    assign drain_ready = !shadow_hold;
    assign drain = fifo_out_valid && drain_ready;
    assign drain_addr = fifo_out_data[15:8];
    assign drain_byte = fifo_out_data[7:0];

    // shadow array: 32 pages of four bytes, then operations space
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            for (int i = 0; i < 256; i++) begin
                regs[i] <= `PGWR_BYTE_RST;
            end
        end else if (drain) begin
            regs[drain_addr] <= drain_byte;
        end
    end

    // word reads for the monitor core, low byte at the even address
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            cfg_rd_word <= 16'h0000;
        end else begin
            cfg_rd_word <= {regs[{cfg_rd_addr[7:1], 1'b1}], regs[{cfg_rd_addr[7:1], 1'b0}]};
        end
    end

    // control bytes of the operations space leave as plain flops
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            balance_control <= `PGWR_BYTE_RST;
            analog_output_select <= `PGWR_BYTE_RST;
            switch_control_override <= `PGWR_BYTE_RST;
            override_control <= `PGWR_BYTE_RST;
            forced_operation <= `PGWR_BYTE_RST;
            nonvolatile_write_enable <= 1'b0;
        end else if (drain) begin
            if (drain_addr == `PGWR_BALANCE) begin
                balance_control <= drain_byte;
            end
            if (drain_addr == `PGWR_ANALOG_OUT) begin
                analog_output_select <= drain_byte;
            end
            if (drain_addr == `PGWR_SWITCH_CTRL) begin
                switch_control_override <= drain_byte;
            end
            if (drain_addr == `PGWR_OVERRIDE) begin
                override_control <= drain_byte;
            end
            if (drain_addr == `PGWR_FORCE_OPS) begin
                forced_operation <= drain_byte;
            end
            if (drain_addr == `PGWR_NV_WR_EN) begin
                // page writes toward the array are the host's to avoid
                nonvolatile_write_enable <= drain_byte[0];
            end
        end
    end

    // current write address for observation
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            addr_counter <= `PGWR_PTR_RST;
        end else begin
            addr_counter <= ptr;
        end
    end
endmodule // pgwr_top

/* File: sim/pgwr_top_monitor.sv */
// port checker of the page-write serial slave
`timescale 1ns/1ps
// ****************************************
// checker
// ****************************************
module pgwr_top_monitor #(
    parameter int WCYC_CYCLES = 20
) (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic scl,
    input wire logic sda_in,
    input wire logic sda_out,
    input wire logic sda_oe,
    input wire logic scl_out,
    input wire logic scl_oe,
    input wire logic [7:0] addr_counter,
    input wire logic write_busy
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!nrst);
    logic [31:0] busy_cnt;
    // length of the write cycle, read when it ends
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            busy_cnt <= 32'h0;
        end else if (write_busy) begin
            busy_cnt <= busy_cnt + 32'h1;
        end else begin
            busy_cnt <= 32'h0;
        end
    end
    // pins may only pull low, never drive high
    a_sda_pull_only: assert property (sda_out == 1'b0) else $error("data pin driven high");
    a_scl_pull_only: assert property (scl_out == 1'b0) else $error("clock pin driven high");
    // acknowledge edges and the start of a stretch only while the clock is low
    a_ack_rise_low: assert property ($rose(sda_oe) |-> !scl) else $error("ack raised with clock high");
    a_ack_fall_low: assert property ($fell(sda_oe) |-> !scl) else $error("ack dropped with clock high");
    a_stretch_low: assert property ($rose(scl_oe) |-> !scl) else $error("stretch began with clock high");
    a_busy_length: assert property ($fell(write_busy) |-> busy_cnt == 32'(WCYC_CYCLES))
        else $error("write cycle length wrong");
    a_busy_silent: assert property (write_busy |-> !sda_oe && !scl_oe) else $error("bus answered while busy");
    a_stop_starts: assert property ($rose(write_busy) |-> $past(scl) && $past(sda_in))
        else $error("write cycle without stop");
    a_page_step: assert property ((addr_counter != $past(addr_counter)) &&
        (addr_counter[7:2] == $past(addr_counter[7:2])) |->
        addr_counter[1:0] == $past(addr_counter[1:0]) + 2'h1) else $error("in-page step wrong");
    c_ack: cover property ($rose(sda_oe));
    c_stretch: cover property ($rose(scl_oe));
    c_busy_done: cover property ($fell(write_busy));
endmodule // pgwr_top_monitor

bind pgwr_top pgwr_top_monitor #(.WCYC_CYCLES(WCYC_CYCLES)) pgwr_top_monitor_inst (.mclk(mclk), .nrst(nrst),
    .scl(scl), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe), .scl_out(scl_out), .scl_oe(scl_oe),
    .addr_counter(addr_counter), .write_busy(write_busy));

/* File: sim/pgwr_host_model.sv */
// serial bus master model driving the slave's clock and data lines
`timescale 1ns/1ps
// ****************************************
// bus master
// ****************************************
module pgwr_host_model (
    input wire logic mclk,
    input wire logic sda_oe,
    input wire logic scl_oe,
    output logic scl_wire,
    output logic sda_wire
);
    logic m_scl = 1'b1;
    logic m_sda = 1'b1;
    int half = 4;
    int stalls = 0;
    // open-drain lines with pull-ups, low when anyone pulls
    assign scl_wire = m_scl & ~scl_oe;
    assign sda_wire = m_sda & ~sda_oe;
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
    endtask
    // one clock pulse; stretching is waited out, bounded so a stuck slave cannot hang us
    task automatic put_bit(input logic b, output logic got);
        int w;
        m_sda <= b;
        tick(half);
        m_scl <= 1'b1;
        w = 0;
        tick(1);
        while (scl_wire !== 1'b1 && w < 3000) begin
            tick(1);
            w++;
        end
        if (w >= 3000) stalls++;
        tick(half);
        got = sda_wire;
        m_scl <= 1'b0;
        tick(half);
    endtask
    // data falls while clock high
    task automatic start();
        m_sda <= 1'b1;
        m_scl <= 1'b1;
        tick(half);
        m_sda <= 1'b0;
        tick(half);
        m_scl <= 1'b0;
        tick(half);
    endtask
    // data rises while clock high, bus then left idle
    task automatic stop();
        m_sda <= 1'b0;
        tick(half);
        m_scl <= 1'b1;
        tick(half);
        m_sda <= 1'b1;
        tick(half);
    endtask
    // msb first, ninth pulse with data released; callers may chain any number
    task automatic put_byte(input logic [7:0] b, output logic ack);
        logic d;
        for (int i = 7; i >= 0; i--) begin
            put_bit(b[i], d);
        end
        put_bit(1'b1, d);
        ack = !d;
    endtask
endmodule // pgwr_host_model

/* File: sim/tb_i2c_page_write_register_map.sv */
// self-checking bench for the page-write serial slave
`timescale 1ns/1ps
// ****************************************
// bench
// ****************************************
module tb_i2c_page_write_register_map;
    logic mclk = 1'b0;
    logic nrst = 1'b0;
    logic addr_sel = 1'b1;
    logic shadow_hold = 1'b0;
    logic [7:0] cfg_rd_addr = 8'h00;
    logic scl, sda_in, sda_out, sda_oe, scl_out, scl_oe, write_busy, nonvolatile_write_enable;
    logic [15:0] cfg_rd_word;
    logic [7:0] addr_counter, balance_control, analog_output_select, switch_control_override;
    logic [7:0] override_control, forced_operation;
    int errors = 0;
    int cmp_count = 0;
    int acks;
    logic stretched = 1'b0;
    logic [7:0] q[$];
    logic [7:0] prot[8] = '{8'h58, 8'h80, 8'h7F, 8'h83, 8'h4C, 8'h8A, 8'hFF, 8'hAB};
    always #4 mclk = ~mclk;
    // remembers any clock stretch seen
    always @(posedge mclk) if (scl_oe) stretched <= 1'b1;
    pgwr_top #(.WCYC_CYCLES(20)) pgwr_top_inst (.mclk(mclk), .nrst(nrst), .scl(scl), .sda_in(sda_in),
        .sda_out(sda_out), .sda_oe(sda_oe), .scl_out(scl_out), .scl_oe(scl_oe), .addr_sel(addr_sel),
        .shadow_hold(shadow_hold), .cfg_rd_addr(cfg_rd_addr), .cfg_rd_word(cfg_rd_word),
        .addr_counter(addr_counter), .write_busy(write_busy), .balance_control(balance_control),
        .analog_output_select(analog_output_select), .switch_control_override(switch_control_override),
        .override_control(override_control), .forced_operation(forced_operation),
        .nonvolatile_write_enable(nonvolatile_write_enable));
    pgwr_host_model pgwr_host_model_inst (.mclk(mclk), .sda_oe(sda_oe), .scl_oe(scl_oe), .scl_wire(scl),
        .sda_wire(sda_in));
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // one transaction of the bytes in q; stop is sent even after a refusal
    task automatic xfer(input int half);
        logic a;
        pgwr_host_model_inst.half = half;
        acks = 0;
        pgwr_host_model_inst.start();
        foreach (q[i]) begin
            pgwr_host_model_inst.put_byte(q[i], a);
            acks += (a === 1'b1) ? 1 : 0;
        end
        pgwr_host_model_inst.stop();
    endtask
    task automatic wait_idle();
        int w;
        w = 0;
        while (write_busy !== 1'b0 && w < 200) begin
            @(posedge mclk);
            w++;
        end
        if (w >= 200) errors++;
        @(posedge mclk);
    endtask
    task automatic rdw(input logic [7:0] a, input logic [15:0] exp);
        cfg_rd_addr <= a;
        repeat (2) @(posedge mclk);
        #1;
        chk(cfg_rd_word, exp);
    endtask
    task automatic final_report();
        $display("comparisons %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // main sequence; slave address byte 0x52 matches address-select high
    initial begin
        repeat (20) @(posedge mclk);
        nrst <= 1'b1;
        repeat (2) @(posedge mclk);
        chk({balance_control, addr_counter}, 16'h0000);
        chk({7'h00, write_busy, switch_control_override}, 16'h0000);
        $display("test reset done");
        q = '{8'h52, 8'h86, 8'hA1, 8'hB2, 8'hC3, 8'hD4};
        xfer(12);
        chk(acks[15:0], 16'h0006);
        wait_idle();
        chk({balance_control, analog_output_select}, 16'hC3D4);
        chk({override_control, switch_control_override}, 16'hB2A1);
        chk({8'h00, addr_counter}, 16'h0086);
        rdw(8'h86, 16'hB2A1);
        $display("test page_wrap done");
        q = '{8'h52, 8'h10, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06};
        xfer(4);
        chk(acks[15:0], 16'h0008);
        wait_idle();
        rdw(8'h10, 16'h0605);
        rdw(8'h12, 16'h0403);
        chk({8'h00, addr_counter}, 16'h0012);
        chk({15'h0000, nonvolatile_write_enable}, 16'h0000);
        $display("test overwrite done");
        foreach (prot[i]) begin
            q = '{8'h52, prot[i], 8'h55};
            xfer(4);
            chk(acks[15:0], 16'h0002);
            chk({15'h0000, write_busy}, 16'h0000);
        end
        q = '{8'h50, 8'h84, 8'h77};
        xfer(4);
        chk(acks[15:0], 16'h0000);
        q = '{8'h53, 8'h84};
        xfer(4);
        chk(acks[15:0], 16'h0000);
        $display("test refusals done");
        q = '{8'h52, 8'h84, 8'h11};
        xfer(4);
        q = '{8'h52, 8'h85, 8'h22};
        xfer(4);
        chk(acks[15:0], 16'h0000);
        wait_idle();
        chk({balance_control, analog_output_select}, 16'h11D4);
        $display("test busy done");
        shadow_hold <= 1'b1;
        fork
            begin
                repeat (1500) @(posedge mclk);
                shadow_hold <= 1'b0;
            end
        join_none
        q = '{8'h52, 8'h50};
        for (int i = 0; i < 10; i++) q.push_back(8'h60 + 8'(i));
        xfer(4);
        chk({stretched, acks[14:0]}, 16'h800C);
        wait_idle();
        rdw(8'h50, 16'h6968);
        rdw(8'h52, 16'h6766);
        $display("test buffer done");
        addr_sel <= 1'b0;
        q = '{8'h50, 8'h88, 8'h5A, 8'h01};
        xfer(4);
        chk(acks[15:0], 16'h0004);
        wait_idle();
        chk({forced_operation, 7'h00, nonvolatile_write_enable}, 16'h5A01);
        chk(pgwr_host_model_inst.stalls[15:0], 16'h0000);
        $display("test control done");
        final_report();
    end
    // cuts a hang short
    initial begin
        repeat (60000) @(posedge mclk);
        errors++;
        final_report();
    end
endmodule // tb_i2c_page_write_register_map
